/* File: reset_state_initializer_bench.sv */
// Self-checking bench for the reset state initializer.
`timescale 1ns/10ps
module reset_state_initializer_bench import rsi_pkg::*; ();
    localparam logic [7:0] MSK [20] = '{8'h0F, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
        8'hEF, 8'h8D, 8'h7F, 8'hFF, 8'hE7, 8'hE7, 8'hE7, 8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F};
    localparam logic [7:0] RES [20] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h03, 8'h00, 8'h00, 8'h00, 8'hE7, 8'hE7, 8'h00, 8'h00, 8'h53, 8'h55, 8'h00, 8'h00, 8'h07};
    logic        mclk_in, reset_in, psel, penable, pwrite, fire;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_out;
    logic        pready_out, pslverr_out, irq_out, counter_clear_out;
    logic        por, pin_n, brown, wdt, sleep;
    rsi_kind_e   kind;
    logic [7:0]  seen [20];
    int          n_errors, total_checks, cycles;

    rsi_init DUT (.mclk_in(mclk_in), .reset_in(reset_in), .por_in(por),
        .ext_clear_pin_n_in(pin_n), .brownout_detector_in(brown), .watchdog_timeout_in(wdt),
        .sleep_mode_in(sleep), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
        .counter_clear_out(counter_clear_out), .status_out(seen[0]),
        .prog_counter_low_out(seen[1]), .bank_pointer_out(seen[2]), .stack_ptr_out(seen[3]),
        .work_register_out(seen[4]), .table_ptr_reg_out(seen[5]),
        .table_high_reg_out(seen[6]), .sysmode_ctl_out(seen[7]),
        .sysmode_flags_reg_out(seen[8]), .irq_ctl_a_out(seen[9]), .irq_ctl_b_out(seen[10]),
        .port_a_data_out(seen[11]), .port_dir_reg_out(seen[12]),
        .port_pullup_en_out(seen[13]), .port_wake_en_out(seen[14]),
        .watchdog_ctl_out(seen[15]), .reset_guard_reg_out(seen[16]),
        .timer_ctl_a_out(seen[17]), .timer_ctl_b_out(seen[18]), .pin_select_out(seen[19]));

    rsi_cause_model model (.mclk_in(mclk_in), .fire_in(fire), .kind_in(kind), .por_out(por),
        .pin_n_out(pin_n), .brown_out(brown), .wdt_out(wdt), .sleep_out(sleep));

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        r = prdata_out;
        e = pslverr_out;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_in);
    endtask : apb

    // Fires one cause and waits for the clear pulse that marks the applied reset.
    task automatic fire_cause(input rsi_kind_e k);
        int n;
        kind <= k;
        fire <= 1'b1;
        @(posedge mclk_in);
        fire <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (counter_clear_out !== 1'b1 && n < 20);
        chk("clear_pulse", 1, counter_clear_out);
    endtask : fire_cause

    // Expected register value after kind k when 5A had been written everywhere.
    function automatic logic [7:0] expv(input int i, input rsi_kind_e k);
        logic [7:0] w;
        w = 8'h5A & MSK[i];
        if (k == RSI_WDT_SLEEP) return (i inside {1, 2, 3, 10}) ? 8'h00 : w;
        if (k != RSI_POWER && i inside {4, 5, 6}) return w;
        if (k != RSI_POWER && i == 8) return (k == RSI_BROWN) ? (w | 8'h04) : w;
        return RES[i];
    endfunction : expv

    // Dirties every register, applies one reset kind and checks the whole file.
    task automatic run_kind(input rsi_kind_e k, input logic [1:0] fl);
        logic [31:0] r;
        logic        e;
        for (int i = 1; i < 20; i++) apb(1'b1, 8'(i * 4), 32'h5A, r, e);
        apb(1'b1, 8'h00, 32'hFA, r, e);
        fire_cause(k);
        chk("status", {2'b00, fl, ((k == RSI_POWER) ? 4'h0 : 4'hA)}, seen[0]);
        for (int i = 1; i < 20; i++) chk($sformatf("reg%0d", i), expv(i, k), seen[i]);
        @(posedge mclk_in);
        chk("clear_end", 0, counter_clear_out);
        apb(1'b0, 8'h68, 32'h0, r, e);
        chk("cause", {29'h0, k}, r);
    endtask : run_kind

    // Event masking, W1C clearing and refused accesses.
    task automatic irq_and_bus;
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'h64, 32'h0, r, e);
        apb(1'b1, 8'h60, 32'h1F, r, e);
        fire_cause(RSI_PIN);
        chk("irq_masked", 0, irq_out);
        apb(1'b0, 8'h60, 32'h0, r, e);
        chk("evt", 32'h2, r);
        apb(1'b1, 8'h64, 32'h2, r, e);
        chk("irq_on", 1, irq_out);
        apb(1'b1, 8'h60, 32'h2, r, e);
        chk("irq_off", 0, irq_out);
        fire_cause(RSI_PIN);
        chk("irq_evt", 1, irq_out);
        apb(1'b0, 8'h50, 32'h0, r, e);
        chk("unmapped_err", 1, e);
        chk("unmapped_data", 0, r);
        apb(1'b0, 8'h06, 32'h0, r, e);
        chk("misaligned_err", 1, e);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk("watchdog_ctl_read", 32'h53, r);
    endtask : irq_and_bus

    // Prints the verdict and ends the run.
    task automatic results;
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // Clock of 100 ns period.
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // Cuts a hang short.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            results();
        end
    end

    // Main sequence.
    initial begin
        reset_in     = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        fire         = 1'b0;
        kind         = RSI_NONE;
        n_errors     = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        for (int i = 0; i < 20; i++) chk($sformatf("rst%0d", i), RES[i], seen[i]);
        run_kind(RSI_WDT_SLEEP, 2'b11);
        run_kind(RSI_PIN, 2'b11);
        run_kind(RSI_POWER, 2'b00);
        run_kind(RSI_WDT_RUN, 2'b10);
        run_kind(RSI_BROWN, 2'b10);
        irq_and_bus();
        // A second reset in mid-run must bring back every power-on value.
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        for (int i = 0; i < 20; i++) chk($sformatf("rerst%0d", i), RES[i], seen[i]);
        chk("rst_irq", 0, irq_out);
        results();
    end
endmodule : reset_state_initializer_bench

/* File: rsi_cause_model.sv */
// Model of the on-chip reset sources that raise the reset cause lines.
`timescale 1ns/10ps
module rsi_cause_model
    import rsi_pkg::*;
(
    input  wire logic      mclk_in,
    input  wire logic      fire_in,
    input  wire rsi_kind_e kind_in,
    output logic           por_out,
    output logic           pin_n_out,
    output logic           brown_out,
    output logic           wdt_out,
    output logic           sleep_out
);
    logic [2:0] hold_q = 3'h0;
    rsi_kind_e  kind_q = RSI_NONE;
    logic       act;

    // One source fires at a time and stands six cycles, long enough to cross the synchronizer.
    always_ff @(posedge mclk_in) begin
        if (fire_in) begin
            hold_q <= 3'h6;
            kind_q <= kind_in;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end

    // Decode the active source onto its line; the pin line idles high.
    always_comb begin
        act       = (hold_q != 3'h0);
        por_out   = act && (kind_q == RSI_POWER);
        pin_n_out = !(act && (kind_q == RSI_PIN));
        brown_out = act && (kind_q == RSI_BROWN);
        wdt_out   = act && (kind_q == RSI_WDT_RUN || kind_q == RSI_WDT_SLEEP);
        sleep_out = act && (kind_q == RSI_WDT_SLEEP);
    end
endmodule : rsi_cause_model

/* File: rsi_defines.svh */
// Offsets, field positions, reset values and masks of the reset state initializer.
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define RSI_IDX_STATUS     5'h00
`define RSI_IDX_PCL        5'h01
`define RSI_IDX_BANK       5'h02
`define RSI_IDX_STACK      5'h03
`define RSI_IDX_WORK       5'h04
`define RSI_IDX_TABLE_PTR_REG       5'h05
`define RSI_IDX_TABLE_HIGH_REG       5'h06
`define RSI_IDX_SYSMODE    5'h07
`define RSI_IDX_SYSFLAGS   5'h08
`define RSI_IDX_IRQA       5'h09
`define RSI_IDX_IRQB       5'h0A
`define RSI_IDX_PORTD      5'h0B
`define RSI_IDX_PORTDIR    5'h0C
`define RSI_IDX_PULLUP     5'h0D
`define RSI_IDX_WAKE       5'h0E
`define RSI_IDX_WATCHDOG_CTL       5'h0F
`define RSI_IDX_GUARD      5'h10
`define RSI_IDX_TMRA       5'h11
`define RSI_IDX_TMRB       5'h12
`define RSI_IDX_PSEL       5'h13
`define RSI_NREG           5'h14

// Byte offsets of the event status, event mask and last cause registers.
`define RSI_OFF_INT_STAT   8'h60
`define RSI_OFF_INT_MASK   8'h64
`define RSI_OFF_CAUSE      8'h68

// Flag positions: expiry and power-down in the status register, brown-out in the system flags register.
`define RSI_BIT_EXPIRY     5
`define RSI_BIT_PWRDN      4
`define RSI_BIT_BROWNOUT   2

// Reset values.
`define RSI_RST_ZERO       8'h00
`define RSI_RST_SYSMODE    8'h03
`define RSI_RST_PORT_HI    8'hE7
`define RSI_RST_WATCHDOG_CTL       8'h53
`define RSI_RST_GUARD      8'h55
`define RSI_RST_PSEL       8'h07

// Software-writable bit masks.
`define RSI_MSK_FULL       8'hFF
`define RSI_MSK_STATUS_SW  8'h0F
`define RSI_MSK_BANK       8'h01
`define RSI_MSK_SIX        8'h3F
`define RSI_MSK_SYSMODE    8'hEF
`define RSI_MSK_SYSFLAGS   8'h8D
`define RSI_MSK_IRQA       8'h7F
`define RSI_MSK_PORT       8'hE7

// Event bits: power, pin, brown-out, watchdog running, watchdog sleeping.
`define RSI_NEVT           5

`endif

/* File: rsi_init.sv */
// Reset state initializer: applies per-cause reset values to core and peripheral registers.
//
// Overview of operation
// (RULE_01) Power-on clears expiry and power-down flags.
// (RULE_02) Pin or brown-out reset keeps both flags.
// (RULE_03) Running watchdog reset sets expiry, keeps power-down.
// (RULE_04) Sleeping watchdog reset sets both flags.
// (RULE_05) Every reset disables interrupt control B; all but sleeping watchdog reset disable A.
// (RULE_06) Reset clears counters, loads watchdog control.
// (RULE_07) Reset clears both timer control registers.
// (RULE_08) Reset makes all port pins inputs.
// (RULE_09) Reset points stack pointer at stack top.
// (RULE_10) Program counter low and bank always cleared.
// (RULE_11) Sleeping watchdog reset keeps remaining registers.
// (RULE_12) Reset loads guard, mode and pin-select.
// (RULE_13) Brown-out sets flag; power-on clears flags.
// (RULE_14) Work and table registers kept except power-on.
// (RULE_15) Sleeping watchdog clears counter, stack, sets expiry.
// (RULE_16) One cause per cycle; power-on wins.
`timescale 1ns/10ps
`include "rsi_defines.svh"
module rsi_init
    import rsi_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        por_in,
    input  wire logic        ext_clear_pin_n_in,
    input  wire logic        brownout_detector_in,
    input  wire logic        watchdog_timeout_in,
    input  wire logic        sleep_mode_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    output logic             counter_clear_out,
    output logic      [7:0]  status_out,
    output logic      [7:0]  prog_counter_low_out,
    output logic      [7:0]  bank_pointer_out,
    output logic      [7:0]  stack_ptr_out,
    output logic      [7:0]  work_register_out,
    output logic      [7:0]  table_ptr_reg_out,
    output logic      [7:0]  table_high_reg_out,
    output logic      [7:0]  sysmode_ctl_out,
    output logic      [7:0]  sysmode_flags_reg_out,
    output logic      [7:0]  irq_ctl_a_out,
    output logic      [7:0]  irq_ctl_b_out,
    output logic      [7:0]  port_a_data_out,
    output logic      [7:0]  port_dir_reg_out,
    output logic      [7:0]  port_pullup_en_out,
    output logic      [7:0]  port_wake_en_out,
    output logic      [7:0]  watchdog_ctl_out,
    output logic      [7:0]  reset_guard_reg_out,
    output logic      [7:0]  timer_ctl_a_out,
    output logic      [7:0]  timer_ctl_b_out,
    output logic      [7:0]  pin_select_out
);

    // Value a register takes for a given reset kind, from its current value.
    function automatic rsi_byte_t rsi_apply(input logic [4:0] idx, input rsi_kind_e kind,
                                            input rsi_byte_t cur);
        logic sleep;
        logic power;
        sleep = (kind == RSI_WDT_SLEEP);
        power = (kind == RSI_POWER);
        case (idx)
            `RSI_IDX_STATUS: begin
                case (kind)
                    RSI_POWER:     rsi_apply = `RSI_RST_ZERO;
                    RSI_WDT_RUN:   rsi_apply = cur | (8'h01 << `RSI_BIT_EXPIRY);
                    RSI_WDT_SLEEP: rsi_apply = cur | (8'h01 << `RSI_BIT_EXPIRY)
                                                   | (8'h01 << `RSI_BIT_PWRDN);
                    default:       rsi_apply = cur;
                endcase
            end
            `RSI_IDX_PCL, `RSI_IDX_BANK, `RSI_IDX_STACK, `RSI_IDX_IRQB:
                rsi_apply = `RSI_RST_ZERO;
            `RSI_IDX_WORK, `RSI_IDX_TABLE_PTR_REG, `RSI_IDX_TABLE_HIGH_REG:
                rsi_apply = power ? `RSI_RST_ZERO : cur;
            `RSI_IDX_SYSFLAGS: begin
                if (power) begin
                    rsi_apply = `RSI_RST_ZERO;
                end else if (kind == RSI_BROWN) begin
                    rsi_apply = cur | (8'h01 << `RSI_BIT_BROWNOUT);
                end else begin
                    rsi_apply = cur;
                end
            end
            `RSI_IDX_SYSMODE:                   rsi_apply = sleep ? cur : `RSI_RST_SYSMODE;
            `RSI_IDX_PORTD, `RSI_IDX_PORTDIR:   rsi_apply = sleep ? cur : `RSI_RST_PORT_HI;
            `RSI_IDX_WATCHDOG_CTL:                      rsi_apply = sleep ? cur : `RSI_RST_WATCHDOG_CTL;
            `RSI_IDX_GUARD:                     rsi_apply = sleep ? cur : `RSI_RST_GUARD;
            `RSI_IDX_PSEL:                      rsi_apply = sleep ? cur : `RSI_RST_PSEL;
            default:                            rsi_apply = sleep ? cur : `RSI_RST_ZERO;
        endcase
    endfunction : rsi_apply

    // Bits of a register that software may write.
    function automatic rsi_byte_t rsi_wmask(input logic [4:0] idx);
        case (idx)
            `RSI_IDX_STATUS:                 rsi_wmask = `RSI_MSK_STATUS_SW;
            `RSI_IDX_BANK:                   rsi_wmask = `RSI_MSK_BANK;
            `RSI_IDX_TABLE_HIGH_REG, `RSI_IDX_PSEL:    rsi_wmask = `RSI_MSK_SIX;
            `RSI_IDX_SYSMODE:                rsi_wmask = `RSI_MSK_SYSMODE;
            `RSI_IDX_SYSFLAGS:               rsi_wmask = `RSI_MSK_SYSFLAGS;
            `RSI_IDX_IRQA:                   rsi_wmask = `RSI_MSK_IRQA;
            `RSI_IDX_PORTD, `RSI_IDX_PORTDIR,
            `RSI_IDX_PULLUP, `RSI_IDX_WAKE:  rsi_wmask = `RSI_MSK_PORT;
            default:                         rsi_wmask = `RSI_MSK_FULL;
        endcase
    endfunction : rsi_wmask

    logic [3:0]            cause_sync;
    logic [3:0]            cause_prev_q;
    logic [3:0]            cause_prev_d;
    logic [3:0]            cause_rise;
    rsi_kind_e             kind;
    rsi_byte_t             regs_q [0:`RSI_NREG-1];
    rsi_byte_t             regs_d [0:`RSI_NREG-1];
    logic [`RSI_NEVT-1:0]  stat_q;
    logic [`RSI_NEVT-1:0]  stat_d;
    logic [`RSI_NEVT-1:0]  mask_q;
    logic [`RSI_NEVT-1:0]  mask_d;
    logic [`RSI_NEVT-1:0]  evt;
    logic [2:0]            cause_q;
    logic [2:0]            cause_d;
    logic                  irq_q;
    logic                  irq_d;
    logic                  clr_q;
    logic                  clr_d;
    logic                  pready_q;
    logic                  pready_d;
    logic                  pslverr_q;
    logic                  pslverr_d;
    logic [31:0]           prdata_q;
    logic [31:0]           prdata_d;
    logic                  wr_done;
    logic                  reg_hit;
    logic [4:0]            idx;

    // Cause inputs come from other domains and a pin; the pin is active low.
    rsi_sync #(.WIDTH(4)) u_sync (
        .clk_in   (mclk_in),
        .reset_in (reset_in),
        .d_in     ({watchdog_timeout_in, brownout_detector_in, ~ext_clear_pin_n_in, por_in}),
        .q_out    (cause_sync)
    );

    // Rising edges of the synchronised causes, then one kind per cycle by priority.
    always_comb begin
        cause_prev_d = cause_sync;
        cause_rise   = cause_sync & ~cause_prev_q;
        if (cause_rise[0]) begin                 // RULE_16
            kind = RSI_POWER;
        end else if (cause_rise[2]) begin
            kind = RSI_BROWN;
        end else if (cause_rise[1]) begin
            kind = RSI_PIN;
        end else if (cause_rise[3]) begin
            kind = sleep_mode_in ? RSI_WDT_SLEEP : RSI_WDT_RUN;
        end else begin
            kind = RSI_NONE;
        end
    end

    // Bus decode: one wait state, then the transfer completes.
    always_comb begin
        idx       = paddr_in[6:2];
        reg_hit   = (paddr_in[1:0] == 2'h0) && !paddr_in[7] && (idx < `RSI_NREG);
        pready_d  = psel_in && penable_in && !pready_q;
        wr_done   = psel_in && penable_in && pready_q && pwrite_in;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            if (reg_hit) begin
                prdata_d = {24'h00_0000, regs_q[idx]};
            end else if (paddr_in == `RSI_OFF_INT_STAT) begin
                prdata_d = {27'h000_0000, stat_q};
            end else if (paddr_in == `RSI_OFF_INT_MASK) begin
                prdata_d = {27'h000_0000, mask_q};
            end else if (paddr_in == `RSI_OFF_CAUSE) begin
                prdata_d = {29'h0000_0000, cause_q};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // Register file: software writes, then a reset kind overrides them.
    always_comb begin
        for (int i = 0; i < `RSI_NREG; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_done && reg_hit) begin
            regs_d[idx] = (regs_q[idx] & ~rsi_wmask(idx)) | (pwdata_in[7:0] & rsi_wmask(idx));
        end
        if (kind != RSI_NONE) begin  // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 RULE_15
            for (int i = 0; i < `RSI_NREG; i++) begin  // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
                regs_d[i] = rsi_apply(5'(i), kind, regs_q[i]);  // RULE_01 RULE_02 RULE_03 RULE_04
            end
        end
        clr_d   = (kind != RSI_NONE);                 // RULE_06
        cause_d = (kind != RSI_NONE) ? 3'(kind) : cause_q;
    end

    // Event flags: a new event wins over a write-one-to-clear in the same cycle.
    always_comb begin
        evt    = '0;
        mask_d = mask_q;
        if (kind != RSI_NONE) begin
            evt[3'(kind) - 3'h1] = 1'b1;
        end
        stat_d = stat_q;
        if (wr_done && (paddr_in == `RSI_OFF_INT_STAT)) begin
            stat_d = stat_q & ~pwdata_in[`RSI_NEVT-1:0];
        end
        if (wr_done && (paddr_in == `RSI_OFF_INT_MASK)) begin
            mask_d = pwdata_in[`RSI_NEVT-1:0];
        end
        stat_d = stat_d | evt;
        irq_d  = |(stat_d & mask_d);
    end

    // All state registers; reset_in acts as a power-on reset.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < `RSI_NREG; i++) begin
                regs_q[i] <= rsi_apply(5'(i), RSI_POWER, `RSI_RST_ZERO);
            end
            cause_prev_q <= 4'h0;
            stat_q       <= '0;
            mask_q       <= '0;
            cause_q      <= 3'h1;
            irq_q        <= 1'b0;
            clr_q        <= 1'b1;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
            prdata_q     <= 32'h0000_0000;
        end else begin
            regs_q       <= regs_d;
            cause_prev_q <= cause_prev_d;
            stat_q       <= stat_d;
            mask_q       <= mask_d;
            cause_q      <= cause_d;
            irq_q        <= irq_d;
            clr_q        <= clr_d;
            pready_q     <= pready_d;
            pslverr_q    <= pslverr_d;
            prdata_q     <= prdata_d;
        end
    end

    // Outputs straight from the registers.
    assign prdata_out            = prdata_q;
    assign pready_out            = pready_q;
    assign pslverr_out           = pslverr_q;
    assign irq_out               = irq_q;
    assign counter_clear_out     = clr_q;
    assign status_out            = regs_q[`RSI_IDX_STATUS];
    assign prog_counter_low_out  = regs_q[`RSI_IDX_PCL];
    assign bank_pointer_out      = regs_q[`RSI_IDX_BANK];
    assign stack_ptr_out         = regs_q[`RSI_IDX_STACK];
    assign work_register_out     = regs_q[`RSI_IDX_WORK];
    assign table_ptr_reg_out     = regs_q[`RSI_IDX_TABLE_PTR_REG];
    assign table_high_reg_out    = regs_q[`RSI_IDX_TABLE_HIGH_REG];
    assign sysmode_ctl_out       = regs_q[`RSI_IDX_SYSMODE];
    assign sysmode_flags_reg_out = regs_q[`RSI_IDX_SYSFLAGS];
    assign irq_ctl_a_out         = regs_q[`RSI_IDX_IRQA];
    assign irq_ctl_b_out         = regs_q[`RSI_IDX_IRQB];
    assign port_a_data_out       = regs_q[`RSI_IDX_PORTD];
    assign port_dir_reg_out      = regs_q[`RSI_IDX_PORTDIR];
    assign port_pullup_en_out    = regs_q[`RSI_IDX_PULLUP];
    assign port_wake_en_out      = regs_q[`RSI_IDX_WAKE];
    assign watchdog_ctl_out      = regs_q[`RSI_IDX_WATCHDOG_CTL];
    assign reset_guard_reg_out   = regs_q[`RSI_IDX_GUARD];
    assign timer_ctl_a_out       = regs_q[`RSI_IDX_TMRA];
    assign timer_ctl_b_out       = regs_q[`RSI_IDX_TMRB];
    assign pin_select_out        = regs_q[`RSI_IDX_PSEL];

    // Checks on the reset effects, one cycle after the kind is chosen.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    AST_POWER_FLAGS: assert property (kind == RSI_POWER |=> status_out[5:4] == 2'b00) // RULE_01
        else $error("power-on did not clear status flags");
    AST_PIN_FLAGS: assert property ((kind == RSI_PIN || kind == RSI_BROWN) // RULE_02
        |=> status_out[5:4] == $past(status_out[5:4]))
        else $error("pin or brown-out reset changed status flags");
    AST_WDT_RUN: assert property (kind == RSI_WDT_RUN // RULE_03
        |=> status_out[5] && status_out[4] == $past(status_out[4]))
        else $error("running watchdog reset flags wrong");
    AST_WDT_SLEEP: assert property (kind == RSI_WDT_SLEEP // RULE_04 RULE_15
        |=> status_out[5:4] == 2'b11 && stack_ptr_out == 8'h00)
        else $error("sleeping watchdog reset flags or stack wrong");
    AST_IRQ_CTL: assert property (kind != RSI_NONE // RULE_05
        |=> irq_ctl_b_out == 8'h00 && (cause_q == 3'(RSI_WDT_SLEEP) || irq_ctl_a_out == 8'h00))
        else $error("interrupt control not cleared");
    AST_WDT_CTL: assert property (kind != RSI_NONE && kind != RSI_WDT_SLEEP // RULE_06
        |=> counter_clear_out && watchdog_ctl_out == 8'h53
            ##1 (!counter_clear_out || $past(kind) != RSI_NONE))
        else $error("watchdog control or counter clear wrong");
    AST_TIMER_PORTS: assert property (kind != RSI_NONE && kind != RSI_WDT_SLEEP // RULE_07 RULE_08
        |=> timer_ctl_a_out == 8'h00 && timer_ctl_b_out == 8'h00
            && port_dir_reg_out == 8'hE7 && port_a_data_out == 8'hE7
            && port_pullup_en_out == 8'h00 && port_wake_en_out == 8'h00)
        else $error("timer or port reset values wrong");
    AST_PC_BANK: assert property (kind != RSI_NONE // RULE_09 RULE_10 RULE_15
        |=> prog_counter_low_out == 8'h00 && bank_pointer_out == 8'h00
            && stack_ptr_out == 8'h00)
        else $error("program counter, bank or stack not cleared");
    AST_SLEEP_KEEP: assert property (kind == RSI_WDT_SLEEP // RULE_11
        |=> $stable(timer_ctl_a_out) && $stable(port_dir_reg_out)
            && $stable(reset_guard_reg_out) && $stable(irq_ctl_a_out))
        else $error("sleeping watchdog reset changed kept registers");
    AST_GUARD: assert property (kind != RSI_NONE && kind != RSI_WDT_SLEEP // RULE_12
        |=> reset_guard_reg_out == 8'h55 && sysmode_ctl_out == 8'h03
            && pin_select_out == 8'h07)
        else $error("guard, mode or pin-select reset values wrong");
    AST_BROWN: assert property (kind == RSI_BROWN |=> sysmode_flags_reg_out[2]) // RULE_13
        else $error("brown-out flag not set");
    AST_WORK: assert property (kind != RSI_NONE && kind != RSI_POWER // RULE_14
        |=> $stable(work_register_out) && $stable(table_ptr_reg_out))
        else $error("work or table register changed");
    AST_PRIO: assert property (cause_rise[0] |=> cause_q == 3'h1) // RULE_16
        else $error("power-on did not take priority");
    AST_IRQ: assert property (kind != RSI_NONE && mask_d[3'(kind) - 3'h1]
        |=> irq_out)
        else $error("unmasked event did not raise the interrupt");

    COV_SLEEP: cover property (kind == RSI_WDT_SLEEP ##1 status_out[5:4] == 2'b11);
    COV_BROWN: cover property (kind == RSI_BROWN ##1 sysmode_flags_reg_out[2]);
    COV_COINCIDE: cover property (cause_rise[0] && cause_rise[1]);
    COV_WRITE: cover property (wr_done && reg_hit ##1 kind != RSI_NONE);

endmodule : rsi_init

/* File: rsi_pkg.sv */
// Types shared by the reset state initializer.
package rsi_pkg;

    // Kind of reset being applied in a cycle.
    typedef enum logic [2:0] {
        RSI_NONE,
        RSI_POWER,
        RSI_PIN,
        RSI_BROWN,
        RSI_WDT_RUN,
        RSI_WDT_SLEEP
    } rsi_kind_e;

    typedef logic [7:0] rsi_byte_t;

endpackage : rsi_pkg

/* File: rsi_sync.sv */
// Two-stage synchronizer for reset cause inputs.
`timescale 1ns/10ps
module rsi_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule : rsi_sync
